// File: inc/bitstream_consts.svh
// constants for the repeating bitstream generator
// assumes inclusion by bare name from design files
`ifndef BITSTREAM_CONSTS_SVH
`define BITSTREAM_CONSTS_SVH

`define BG_WORD_W     8
`define BG_MSB        7
`define BG_IDX_W      3
`define BG_LEN_W      7
`define BG_CNT_W      6
`define BG_NODES      15
`define BG_ROOT       14
`define BG_LEAVES     8
`define BG_LVL0_END   4
`define BG_LVL1_END   6
`define BG_LEN_MAX    7'h40
`define BG_LEN_RESET  7'h40
`define BG_LEN_ONE    7'h01
`define BG_WORD_RESET 8'h00
`define BG_IDX_ZERO   3'h0
`define BG_IDX_ONE    3'h1
`define BG_IDX_LAST   3'h7
`define BG_CNT_ZERO   6'h00

`endif

// File: inc/bitstream_pkg.sv
// types shared by the repeating bitstream generator
// assumes nothing of its surroundings
package bitstream_pkg;
  // what a host rewrite targets
  typedef enum logic {CFG_RAM, CFG_LEN} cfg_kind_e;
  // sequencer run state
  typedef enum logic {SEQ_REST, SEQ_RUN} run_e;
endpackage

// File: hdl/repeating_bitstream_generator.sv
// repeating serial bit pattern generator with host rewrite port
// assumes host port on clk_sys_in, link logic on clk_link_in,
// enable and start pins asynchronous to both clocks
`timescale 1ns/1ps
`include "bitstream_consts.svh"

module repeating_bitstream_generator (
  // system clock, reset and freeze
  input  wire logic                      clk_sys_in,
  input  wire logic                      resetn_in,
  input  wire logic                      ce_in,
  // host rewrite port
  input  wire logic                      cfg_wr_in,
  input  wire bitstream_pkg::cfg_kind_e  cfg_kind_in,
  input  wire logic [`BG_IDX_W-1:0]      cfg_addr_in,
  input  wire logic [`BG_WORD_W-1:0]     cfg_data_in,
  output logic                           cfg_busy_out,
  // pattern control pins
  input  wire logic                      enable_in,
  input  wire logic                      start_input_in,
  // serial link
  input  wire logic                      clk_link_in,
  output logic                           serial_clk_out,
  output logic                           serial_data_out
);
  import bitstream_pkg::*;

  logic [1:0]              rst_sys_ff;
  logic [1:0]              rst_link_ff;
  logic                    rst_sys_n;
  logic                    rst_link_n;
  logic                    req_tog_ff;
  logic [1:0]              ack_sync_ff;
  cfg_kind_e               hold_kind_ff;
  logic [`BG_IDX_W-1:0]    hold_addr_ff;
  logic [`BG_WORD_W-1:0]   hold_data_ff;
  logic [1:0]              req_sync_ff;
  logic [1:0]              ce_sync_ff;
  logic [1:0]              en_sync_ff;
  logic [1:0]              start_sync_ff;
  logic                    start_prev_ff;
  logic                    ack_tog_ff;
  logic [`BG_WORD_W-1:0]   ram_ff [0:`BG_LEAVES-1];
  logic [`BG_LEN_W-1:0]    len_preset_ff;
  logic [`BG_CNT_W-1:0]    len_cnt_ff;
  run_e                    run_ff;
  logic [`BG_IDX_W-1:0]    state_ff;
  logic [`BG_IDX_W-1:0]    bit_sel_ff;
  logic                    phase_ff;
  logic                    data_ff;

  // reset release, one two-flop copy per domain
  assign rst_sys_n  = rst_sys_ff[1];
  assign rst_link_n = rst_link_ff[1];

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) rst_sys_ff <= 2'b00;
    else            rst_sys_ff <= {rst_sys_ff[0], 1'b1};
  end

  always_ff @(posedge clk_link_in or negedge resetn_in) begin
    if (!resetn_in) rst_link_ff <= 2'b00;
    else            rst_link_ff <= {rst_link_ff[0], 1'b1};
  end

  // host side of the toggle handshake; holds stay put while busy
  wire take_w = cfg_wr_in & ~cfg_busy_out & ce_in;
  assign cfg_busy_out = req_tog_ff ^ ack_sync_ff[1];

  always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      req_tog_ff   <= 1'b0;
      ack_sync_ff  <= 2'b00;
      hold_kind_ff <= CFG_RAM;
      hold_addr_ff <= `BG_IDX_ZERO;
      hold_data_ff <= `BG_WORD_RESET;
    end else if (ce_in) begin
      ack_sync_ff <= {ack_sync_ff[0], ack_tog_ff};
      if (take_w) begin
        req_tog_ff   <= ~req_tog_ff;
        hold_kind_ff <= cfg_kind_in;
        hold_addr_ff <= cfg_addr_in;
        hold_data_ff <= cfg_data_in;
      end
    end
  end

  // pin and crossing synchronisers; never frozen so ce itself can pass
  always_ff @(posedge clk_link_in or negedge rst_link_n) begin
    if (!rst_link_n) begin
      req_sync_ff   <= 2'b00;
      ce_sync_ff    <= 2'b00;
      en_sync_ff    <= 2'b00;
      start_sync_ff <= 2'b00;
    end else begin
      req_sync_ff   <= {req_sync_ff[0], req_tog_ff};
      ce_sync_ff    <= {ce_sync_ff[0], ce_in};
      en_sync_ff    <= {en_sync_ff[0], enable_in};
      start_sync_ff <= {start_sync_ff[0], start_input_in};
    end
  end

  // link-domain views of the crossed signals
  wire ce_link_w    = ce_sync_ff[1];
  wire en_link_w    = en_sync_ff[1];
  wire start_rise_w = start_sync_ff[1] & ~start_prev_ff;
  wire link_wr_w    = (req_sync_ff[1] ^ ack_tog_ff) & ce_link_w;
  wire ram_wr_w     = link_wr_w & (hold_kind_ff == CFG_RAM);
  wire len_wr_w     = link_wr_w & (hold_kind_ff == CFG_LEN);
  // zero or oversize lengths fall back to the full 64 bits
  wire len_ok_w     = (hold_data_ff != `BG_WORD_RESET) &&
                      (hold_data_ff <= {1'b0, `BG_LEN_MAX});
  wire [`BG_LEN_W-1:0] nxt_preset = len_ok_w ?
                      hold_data_ff[`BG_LEN_W-1:0] : `BG_LEN_MAX;

  // handshake return and start edge memory
  always_ff @(posedge clk_link_in or negedge rst_link_n) begin
    if (!rst_link_n) begin
      ack_tog_ff    <= 1'b0;
      start_prev_ff <= 1'b0;
    end else if (ce_link_w) begin
      ack_tog_ff    <= req_sync_ff[1];
      start_prev_ff <= start_sync_ff[1];
    end
  end

  // length preset, host rewritable
  always_ff @(posedge clk_link_in or negedge rst_link_n) begin
    if (!rst_link_n) len_preset_ff <= `BG_LEN_RESET;
    else if (len_wr_w) len_preset_ff <= nxt_preset;
  end

  // per-state output words, one per chain state
  genvar gi;
  generate
    for (gi = 0; gi < `BG_LEAVES; gi++) begin : g_ram
      always_ff @(posedge clk_link_in or negedge rst_link_n) begin
        if (!rst_link_n) begin
          ram_ff[gi] <= `BG_WORD_RESET;
        end else if (ram_wr_w && hold_addr_ff == gi) begin
          ram_ff[gi] <= hold_data_ff;
        end
      end
    end
  endgenerate

  // derived clock: high half of each bit, gated by enable
  wire running_w = (run_ff == SEQ_RUN);
  wire step_w    = ce_link_w & en_link_w & running_w & phase_ff;
  wire wrap_w    = step_w & (len_cnt_ff == `BG_CNT_ZERO);
  assign serial_clk_out = phase_ff & en_link_w;

  // transition conditions; each needs its own state, so at most one
  logic [`BG_LEAVES-1:0] trans_cond_w;
  generate
    for (gi = 0; gi < `BG_LEAVES; gi++) begin : g_cond
      assign trans_cond_w[gi] = step_w & (state_ff == gi) &
                                (bit_sel_ff == `BG_IDX_LAST);
    end
  endgenerate

  // next sequencer position; wrap outranks a byte step
  wire [`BG_CNT_W-1:0] preset_m1_w =
    6'(len_preset_ff - `BG_LEN_ONE);
  wire [`BG_IDX_W-1:0] nxt_state =
    (!running_w || wrap_w) ? `BG_IDX_ZERO :
    (|trans_cond_w) ? state_ff + `BG_IDX_ONE : state_ff;
  wire [`BG_IDX_W-1:0] nxt_bit_sel =
    (!running_w || wrap_w) ? `BG_IDX_ZERO :
    step_w ? bit_sel_ff + `BG_IDX_ONE : bit_sel_ff;
  wire [`BG_CNT_W-1:0] nxt_len =
    (!running_w || wrap_w) ? preset_m1_w :
    step_w ? len_cnt_ff - 6'h01 : len_cnt_ff;

  // selector tree on the word of the next state, msb first
  wire [`BG_WORD_W-1:0] ram_rd_w = ram_ff[nxt_state];
  wire                  cur_msb_w = ram_ff[state_ff][`BG_MSB];
  logic [`BG_NODES-1:0] node_w;

  function automatic logic sel_stage(input logic upper,
                                     input logic middle,
                                     input logic in1,
                                     input logic in0);
    sel_stage = upper ? 1'b0 : (middle ? in1 : in0);
  endfunction

  generate
    for (gi = 0; gi < `BG_LEAVES; gi++) begin : g_leaf
      assign node_w[gi] = ram_rd_w[`BG_MSB-gi];
    end
    for (gi = 0; gi < `BG_LEAVES - 1; gi++) begin : g_stage
      localparam int LVL = (gi < `BG_LVL0_END) ? 0 :
                           (gi < `BG_LVL1_END) ? 1 : 2;
      // only the root honours the upper select, idling at zero
      wire upper_w = (gi == `BG_LEAVES - 2) ? ~en_link_w : 1'b0;
      assign node_w[`BG_LEAVES+gi] = sel_stage(upper_w, nxt_bit_sel[LVL],
                                     node_w[2*gi+1], node_w[2*gi]);
    end
  endgenerate

  // idle shows the msb; running shows the selected bit
  wire nxt_data = (en_link_w & running_w) ?
                  node_w[`BG_ROOT] : ram_rd_w[`BG_MSB];
  assign serial_data_out = data_ff;

  // sequencer registers; reset rests in state zero, length reloaded
  always_ff @(posedge clk_link_in or negedge rst_link_n) begin
    if (!rst_link_n) begin
      run_ff     <= SEQ_REST;
      state_ff   <= `BG_IDX_ZERO;
      bit_sel_ff <= `BG_IDX_ZERO;
      len_cnt_ff <= 6'(`BG_LEN_RESET - `BG_LEN_ONE);
      phase_ff   <= 1'b0;
      data_ff    <= 1'b0;
    end else if (ce_link_w) begin
      if (start_rise_w) run_ff <= SEQ_RUN;
      state_ff   <= nxt_state;
      bit_sel_ff <= nxt_bit_sel;
      len_cnt_ff <= nxt_len;
      phase_ff   <= running_w & en_link_w & ~phase_ff;
      data_ff    <= nxt_data;
    end
  end

  // checks on the link-side behaviour
  default clocking cb_link @(posedge clk_link_in); endclocking
  default disable iff (!rst_link_n);

  sequence s_bit_end;
    step_w;
  endsequence

  sequence s_wrap;
    s_bit_end ##0 (len_cnt_ff == `BG_CNT_ZERO);
  endsequence

  a_rest_state: assert property (
    !running_w |-> state_ff == `BG_IDX_ZERO)
    else $error("sequencer left state zero before start");
  a_start_run: assert property (
    (ce_link_w && start_rise_w && !running_w) |=> running_w)
    else $error("start edge did not begin the pattern");
  a_state_hold: assert property (
    (running_w && !step_w) |=> $stable(state_ff))
    else $error("state moved without a derived clock edge");
  a_cond_guard: assert property (
    $onehot0(trans_cond_w))
    else $error("two transition conditions high together");
  a_clk_gate: assert property (
    !en_link_w |-> !serial_clk_out)
    else $error("serial clock ran while enable low");
  a_idle_msb: assert property (
    (ce_link_w && !en_link_w) ##1 ce_link_w |->
    serial_data_out == $past(cur_msb_w))
    else $error("idle data differs from current word msb");
  a_bit_order: assert property (
    s_bit_end ##0 (len_cnt_ff != `BG_CNT_ZERO) |=>
    bit_sel_ff == $past(bit_sel_ff) + `BG_IDX_ONE)
    else $error("bit select did not advance by one");
  a_len_reload: assert property (
    s_wrap |=> len_cnt_ff == $past(preset_m1_w))
    else $error("length counter not reloaded from preset");
  a_wrap_zero: assert property (
    s_wrap |=> state_ff == `BG_IDX_ZERO && bit_sel_ff == `BG_IDX_ZERO)
    else $error("pattern did not restart after its last bit");
  a_state_step: assert property (
    (|trans_cond_w && !wrap_w) |=>
    state_ff == $past(state_ff) + `BG_IDX_ONE)
    else $error("chain did not step to the next state");
  a_ram_write: assert property (
    ram_wr_w |=> ram_ff[$past(hold_addr_ff)] == $past(hold_data_ff))
    else $error("host word not stored");

  // selector tree and freeze; the tree is wired leaf by leaf, so a
  // swapped leaf would show up here and in the bench bit compare
  a_sel_pick: assert property (
    (ce_link_w && en_link_w && running_w) |=>
    serial_data_out == $past(ram_rd_w[`BG_MSB - nxt_bit_sel]))
    else $error("selected bit differs from word bit");
  a_sel_zero: assert property (
    !en_link_w |-> !node_w[`BG_ROOT])
    else $error("root stage not zero with upper select high");
  a_ce_freeze: assert property (
    !ce_link_w |=> $stable(state_ff) && $stable(bit_sel_ff) &&
    $stable(phase_ff) && $stable(len_cnt_ff))
    else $error("sequencer moved while frozen");

  // host side runs on the system clock with its own reset copy
  a_take_busy: assert property (
    @(posedge clk_sys_in) disable iff (!rst_sys_n)
    take_w |=> cfg_busy_out)
    else $error("taken write did not raise busy");

endmodule

// File: bench/serial_receiver.sv
// behavioural receiver of the synchronous serial bit pattern
// assumes data is stable while the serial clock is high
`timescale 1ns/1ps

module serial_receiver (
  // link from the generator
  input  wire logic        serial_clk_in,
  input  wire logic        serial_data_in,
  input  wire logic        resetn_in,
  // captured bit and running count
  output logic             bit_out,
  output logic [15:0]      count_out
);
  // capture on the rising serial clock, mid-bit for best margin
  always_ff @(posedge serial_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_out   <= 1'b0;
      count_out <= 16'h0000;
    end else begin
      bit_out   <= serial_data_in;
      count_out <= count_out + 16'h0001;
    end
  end
endmodule

// File: bench/testbench.sv
// self-checking bench for the repeating bitstream generator
// assumes the serial receiver model sits on the link outputs
`timescale 1ns/1ps

module testbench;
  import bitstream_pkg::*;
  logic        clk_sys, clk_link, resetn, wr, busy;
  logic        enable, start, sclk, sdata, rx_bit, chk_on, ce;
  cfg_kind_e   kind;
  logic [2:0]  addr;
  logic [7:0]  data;
  logic [15:0] rx_count;
  logic [7:0]  words [8];
  int          len, failures, cmp_count;

  repeating_bitstream_generator i_repeating_bitstream_generator (
    .clk_sys_in(clk_sys), .resetn_in(resetn), .ce_in(ce),
    .cfg_wr_in(wr), .cfg_kind_in(kind), .cfg_addr_in(addr),
    .cfg_data_in(data), .cfg_busy_out(busy), .enable_in(enable),
    .start_input_in(start), .clk_link_in(clk_link),
    .serial_clk_out(sclk), .serial_data_out(sdata));

  serial_receiver i_serial_receiver (
    .serial_clk_in(sclk), .serial_data_in(sdata), .resetn_in(resetn),
    .bit_out(rx_bit), .count_out(rx_count));

  // clocks: link phase offset so the domains never line up
  always #4 clk_sys = ~clk_sys;
  initial begin
    clk_link = 1'b0;
    #3.3;
    forever #40 clk_link = ~clk_link;
  end

  // bit n of the repeating pattern, msb of word 0 first
  function automatic logic exp_bit(input int n);
    int p;
    p = n % len;
    return words[p / 8][7 - (p % 8)];
  endfunction

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // every received bit is compared against the pattern
  always @(rx_count) begin
    #1;
    if (chk_on && rx_count != 16'h0000)
      check(rx_bit === exp_bit(int'(rx_count) - 1), "bit");
  end

  task automatic reset_dut;
    // a real falling edge, so the async resets see it even at start
    @(posedge clk_sys);
    #1 resetn = 1'b0;
    start = 1'b0;
    enable = 1'b0;
    chk_on = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    check(sclk === 1'b0 && sdata === 1'b0, "reset outs");
    check(busy === 1'b0, "reset busy");
    resetn = 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask

  // one write, waits for the crossing to finish under a bound
  task automatic host_write(input cfg_kind_e k, input logic [2:0] a,
                            input logic [7:0] d);
    int t;
    @(posedge clk_sys);
    #1 wr = 1'b1;
    kind = k;
    addr = a;
    data = d;
    @(posedge clk_sys);
    #1 wr = 1'b0;
    check(busy === 1'b1, "busy");
    for (t = 0; t < 100 && busy !== 1'b0; t++) begin
      @(posedge clk_sys);
      #1;
    end
    check(busy === 1'b0, "busy stuck");
  endtask

  task automatic wait_bits(input int n);
    int t;
    for (t = 0; t < n * 4 + 50 && rx_count < n; t++) @(posedge clk_link);
    check(rx_count >= n, "stream stalled");
  endtask

  task automatic run_pattern;
    int c, t;
    @(posedge clk_sys);
    #1 start = 1'b1;
    chk_on = 1'b1;
    repeat (6) @(posedge clk_link);
    #1;
    check(sclk === 1'b0 && rx_count === 16'h0000, "clk idle");
    check(sdata === words[0][7], "rest msb");
    @(posedge clk_sys);
    #1 enable = 1'b1;
    wait_bits(len + 5);
    // freeze: no serial clock and no host write while ce is low
    @(posedge clk_sys);
    #1 ce = 1'b0;
    repeat (4) @(posedge clk_link);
    c = rx_count;
    @(posedge clk_sys);
    #1 wr = 1'b1;
    kind = CFG_RAM;
    addr = 3'h0;
    data = ~words[0];
    @(posedge clk_sys);
    #1 wr = 1'b0;
    check(busy === 1'b0, "write taken while frozen");
    repeat (8) @(posedge clk_link);
    #1;
    check(rx_count === 16'(c), "count moved while frozen");
    @(posedge clk_sys);
    #1 ce = 1'b1;
    @(posedge clk_sys);
    #1 enable = 1'b0;
    repeat (6) @(posedge clk_link);
    c = rx_count;
    // pause: clock held low, data is msb of the state in hand
    for (t = 0; t < 20; t++) begin
      @(posedge clk_link);
      #1;
      check(sclk === 1'b0, "clk in pause");
    end
    check(sdata === words[(c % len) / 8][7] ||
          sdata === words[((c + len - 1) % len) / 8][7], "msb");
    @(posedge clk_sys);
    #1 enable = 1'b1;
    wait_bits(2 * len + 10);
    chk_on = 1'b0;
  endtask

  initial begin
    int lens [4];
    int r, i, lv;
    clk_sys = 1'b0;
    resetn = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    kind = CFG_RAM;
    addr = 3'h0;
    data = 8'h00;
    enable = 1'b0;
    start = 1'b0;
    chk_on = 1'b0;
    failures = 0;
    cmp_count = 0;
    len = 64;
    lens = '{0, 1, 9, 64};
    void'($urandom(78716));
    for (r = 0; r < 4; r++) begin
      reset_dut;
      lv = (r == 3) ? 2 + ($urandom % 63) : lens[r];
      len = (lv == 0 || lv > 64) ? 64 : lv;
      for (i = 0; i < 8; i++) begin
        words[i] = 8'($urandom);
        host_write(CFG_RAM, 3'(i), words[i]);
      end
      host_write(CFG_LEN, 3'h0, 8'(lv));
      run_pattern;
    end
    stop_test;
  end

  // watchdog: four runs take at most about 75 us, so 400 us means a hang
  initial begin
    #400000;
    failures++;
    stop_test;
  end
endmodule
